// >>> hdl/pif_pkg.sv
// Purpose: Constants for the peripheral interrupt flag register block.
// Assumes: APB slave with 32-bit data, one register word.
// Notes:   Field positions follow the flag order from bit 7 down to bit 0.
package pif_pkg;
    localparam logic [11:0] PIF_FLAGS_ADDR     = 12'h00C;
    localparam logic [7:0]  PIF_FLAGS_RESET    = 8'h00;
    localparam int          PIF_BIT_SLAVE_PORT = 7;
    localparam int          PIF_BIT_CONV_DONE  = 6;
    localparam int          PIF_BIT_RX_FULL    = 5;
    localparam int          PIF_BIT_TX_EMPTY   = 4;
    localparam int          PIF_BIT_SYNC_SER   = 3;
    localparam int          PIF_BIT_CAP_CMP    = 2;
    localparam int          PIF_BIT_TIMER_TWO  = 1;
    localparam int          PIF_BIT_TIMER_ONE  = 0;
    // Bits software may clear; the two serial buffer bits are live status.
    localparam logic [7:0]  PIF_WRITABLE_MASK  = 8'hCF;
    localparam logic [1:0]  PIF_CCP_CAPTURE    = 2'h0;
    localparam logic [1:0]  PIF_CCP_COMPARE    = 2'h1;
    localparam logic [1:0]  PIF_CCP_PWM        = 2'h2;
endpackage : pif_pkg

// >>> hdl/pif_flags.sv
// Purpose: Peripheral interrupt flag register behind an APB slave.
// Assumes: Event inputs are one-cycle pulses from logic on pclk.
// Notes:   Serial buffer levels arrive from pclk logic and need no synchroniser.
`timescale 1ns/100ps

// Operation
// - Flags set on their condition regardless of any enable bit.
// - Register at address 0x0C, eight bits, resets to zero.
// - Bits 7..0: slave port, conversion, rx, tx, sync serial, ccp1, timer2, timer1.
// - Bit 7 sets on a parallel slave port access, held until cleared.
// - Bit 6 sets on conversion done, held until cleared.
// - Bit 5 mirrors receive buffer full; read only.
// - Bit 4 mirrors transmit buffer empty; read only.
// - Bit 2 sets on capture or compare per mode; unused in PWM.
module pif_flags (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        slave_port_access,
    input  wire logic        conversion_done,
    input  wire logic        serial_rx_full,
    input  wire logic        serial_tx_empty,
    input  wire logic        sync_serial_event,
    input  wire logic [1:0]  ccp_mode,
    input  wire logic        ccp_capture,
    input  wire logic        ccp_compare,
    input  wire logic        timer_two_match,
    input  wire logic        timer_one_overflow,
    output logic      [7:0]  peripheral_irq_flags
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Places the two live serial buffer levels over a stored flag byte.
    function automatic logic [7:0] pif_overlay_live(
        input logic [7:0] stored,
        input logic       rx_full,
        input logic       tx_empty
    );
        logic [7:0] result;
        result                            = stored;
        result[pif_pkg::PIF_BIT_RX_FULL]  = rx_full;
        result[pif_pkg::PIF_BIT_TX_EMPTY] = tx_empty;
        return result;
    endfunction : pif_overlay_live

    // Next value of one writable flag; a set in the same cycle beats a clear.
    function automatic logic pif_flag_step(
        input logic current,
        input logic set_pulse,
        input logic write_commit,
        input logic write_bit
    );
        logic kept;
        kept = current;
        if (write_commit && !write_bit) begin
            kept = 1'b0;
        end
        return kept | set_pulse;
    endfunction : pif_flag_step

    // True when the bus address selects the flag register.
    function automatic logic pif_addr_hit(
        input logic [11:0] addr
    );
        return (addr == pif_pkg::PIF_FLAGS_ADDR);
    endfunction : pif_addr_hit

    // ----------------------------------------------------------------
    // Event collection
    // ----------------------------------------------------------------
    logic [7:0] set_vec;
    logic       ccp_event;

    always_comb begin
        case (ccp_mode)
            pif_pkg::PIF_CCP_CAPTURE: ccp_event = ccp_capture;
            pif_pkg::PIF_CCP_COMPARE: ccp_event = ccp_compare;
            default:                  ccp_event = 1'b0;
        endcase
        set_vec                                = 8'h00;
        set_vec[pif_pkg::PIF_BIT_SLAVE_PORT]   = slave_port_access;
        set_vec[pif_pkg::PIF_BIT_CONV_DONE]    = conversion_done;
        set_vec[pif_pkg::PIF_BIT_SYNC_SER]     = sync_serial_event;
        set_vec[pif_pkg::PIF_BIT_CAP_CMP]      = ccp_event;
        set_vec[pif_pkg::PIF_BIT_TIMER_TWO]    = timer_two_match;
        set_vec[pif_pkg::PIF_BIT_TIMER_ONE]    = timer_one_overflow;
    end

    // ----------------------------------------------------------------
    // Flag register and APB slave
    // ----------------------------------------------------------------
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  view_reg;
    logic [7:0]  view_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        hit;
    logic        access;
    logic        wr;
    logic [7:0]  rd_val;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // The first access edge only arms the answer; a write lands at the
    // edge where the master samples pready high, so it cannot land twice.
    always_comb begin
        access = psel && penable && !pready_reg;
        hit    = pif_addr_hit(paddr);
        wr     = psel && penable && pready_reg && pwrite && hit && pstrb[0];
    end

    // ----------------------------------------------------------------
    // Flag next values
    // ----------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        flags_next[pif_pkg::PIF_BIT_SLAVE_PORT] = pif_flag_step(
            flags_reg[pif_pkg::PIF_BIT_SLAVE_PORT],
            set_vec[pif_pkg::PIF_BIT_SLAVE_PORT],
            wr,
            pwdata[pif_pkg::PIF_BIT_SLAVE_PORT]
        );
        flags_next[pif_pkg::PIF_BIT_CONV_DONE] = pif_flag_step(
            flags_reg[pif_pkg::PIF_BIT_CONV_DONE],
            set_vec[pif_pkg::PIF_BIT_CONV_DONE],
            wr,
            pwdata[pif_pkg::PIF_BIT_CONV_DONE]
        );
        flags_next[pif_pkg::PIF_BIT_SYNC_SER] = pif_flag_step(
            flags_reg[pif_pkg::PIF_BIT_SYNC_SER],
            set_vec[pif_pkg::PIF_BIT_SYNC_SER],
            wr,
            pwdata[pif_pkg::PIF_BIT_SYNC_SER]
        );
        flags_next[pif_pkg::PIF_BIT_CAP_CMP] = pif_flag_step(
            flags_reg[pif_pkg::PIF_BIT_CAP_CMP],
            set_vec[pif_pkg::PIF_BIT_CAP_CMP],
            wr,
            pwdata[pif_pkg::PIF_BIT_CAP_CMP]
        );
        flags_next[pif_pkg::PIF_BIT_TIMER_TWO] = pif_flag_step(
            flags_reg[pif_pkg::PIF_BIT_TIMER_TWO],
            set_vec[pif_pkg::PIF_BIT_TIMER_TWO],
            wr,
            pwdata[pif_pkg::PIF_BIT_TIMER_TWO]
        );
        flags_next[pif_pkg::PIF_BIT_TIMER_ONE] = pif_flag_step(
            flags_reg[pif_pkg::PIF_BIT_TIMER_ONE],
            set_vec[pif_pkg::PIF_BIT_TIMER_ONE],
            wr,
            pwdata[pif_pkg::PIF_BIT_TIMER_ONE]
        );
        // The serial buffer bits are never stored; they are shown live.
        flags_next[pif_pkg::PIF_BIT_RX_FULL]  = 1'b0;
        flags_next[pif_pkg::PIF_BIT_TX_EMPTY] = 1'b0;
    end

    // ----------------------------------------------------------------
    // Visible and readable views
    // ----------------------------------------------------------------
    always_comb begin
        view_next = pif_overlay_live(flags_next, serial_rx_full, serial_tx_empty);
        rd_val    = pif_overlay_live(flags_reg, serial_rx_full, serial_tx_empty);
    end

    // ----------------------------------------------------------------
    // Bus response
    // ----------------------------------------------------------------
    always_comb begin
        pready_next  = access;
        pslverr_next = access && !hit;
        prdata_next  = 32'h0000_0000;
        if (access && !pwrite && hit) begin
            prdata_next = {24'h00_0000, rd_val};
        end
    end

    // ----------------------------------------------------------------
    // Flag and view registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= pif_pkg::PIF_FLAGS_RESET;
            view_reg  <= pif_pkg::PIF_FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
            view_reg  <= view_next;
        end
    end

    // ----------------------------------------------------------------
    // Bus response registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata               = prdata_reg;
    assign pready               = pready_reg;
    assign pslverr              = pslverr_reg;
    assign peripheral_irq_flags = view_reg;

endmodule : pif_flags

// >>> sim/pif_flags_monitor.sv
// Purpose: Port checker for the flag block.
// Assumes: One clock domain.
// Notes:   Bound below.
`timescale 1ns/100ps
module pif_flags_monitor (
    input wire logic pclk, presetn, psel, penable, pready, pslverr, slave_port_access, conversion_done,
    input wire logic serial_rx_full, serial_tx_empty, timer_one_overflow, input wire logic [1:0] ccp_mode,
    input wire logic [11:0] paddr, input wire logic [7:0] peripheral_irq_flags);
    wire [7:0] f = peripheral_irq_flags;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rx_live: assert property ($past(presetn) |-> f[5] == $past(serial_rx_full)) else $error("rx");
    a_tx_live: assert property ($past(presetn) |-> f[4] == $past(serial_tx_empty)) else $error("tx");
    a_port_set: assert property (slave_port_access |=> f[7]) else $error("port");
    a_conv_set: assert property (conversion_done |=> f[6]) else $error("conv");
    a_timer_set: assert property (timer_one_overflow |=> f[0]) else $error("timer");
    a_pwm_quiet: assert property (ccp_mode[1] && !f[2] |=> !f[2]) else $error("pwm");
    a_map_err: assert property (pready |-> pslverr == (paddr != 12'h00C)) else $error("decode");
    a_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("wait");
endmodule : pif_flags_monitor
bind pif_flags pif_flags_monitor pif_flags_monitor_i (.*);

// >>> sim/pif_periph.sv
// Purpose: Peripheral side model.
// Assumes: Bench requests per cycle.
// Notes:   Bits 5 and 4 stay levels.
`timescale 1ns/100ps
module pif_periph (input wire logic pclk, input wire logic [7:0] req, output logic [7:0] ev);
    always_ff @(posedge pclk) ev <= req;
endmodule : pif_periph

// >>> sim/test_pif_flags.sv
// Purpose: Bench for the flag block.
// Assumes: APB slave answers with one wait state.
// Notes:   Serial buffer levels follow lvl.
`timescale 1ns/100ps
module test_pif_flags;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0] req = 0, lvl = 0, ev;
    logic [1:0] ccp_mode = 0;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] flg;
    int n_errors = 0, checks_done = 0;
    always #2 pclk = ~pclk;
    pif_periph pif_periph_i (.pclk(pclk), .req(req), .ev(ev));
    pif_flags pif_flags_i (.*, .slave_port_access(ev[7]), .conversion_done(ev[6]),
        .serial_rx_full(ev[5]), .serial_tx_empty(ev[4]), .sync_serial_event(ev[3]), .ccp_capture(ev[2]),
        .ccp_compare(ev[2]), .timer_two_match(ev[1]), .timer_one_overflow(ev[0]), .peripheral_irq_flags(flg));
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
        checks_done++;
        if (y !== x) begin n_errors++; $display("[ERR] %s exp %h got %h", s, x, y); end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk) penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata; e = pslverr; psel <= 1'h0; penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    task automatic fire(input logic [7:0] v); req <= v | lvl; @(posedge pclk) req <= lvl; endtask : fire
    task automatic finish_test;
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin #20000; n_errors++; finish_test; end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h00C, 8'h0); chk("reset", 32'h0, rd);
        lvl = 8'h30; fire(8'hCF);
        apb(1'h0, 12'h00C, 8'h0); chk("set", 32'hFF, rd);
        apb(1'h1, 12'h00C, 8'h0); apb(1'h0, 12'h00C, 8'h0); chk("clear", 32'h30, rd);
        ccp_mode <= 2'h2; fire(8'h04);
        apb(1'h0, 12'h00C, 8'h0); chk("pwm", 32'h30, rd);
        ccp_mode <= 2'h1; fire(8'h04); lvl = 8'h10; fire(8'h0);
        apb(1'h1, 12'h00C, 8'hFF); apb(1'h0, 12'h00C, 8'h0); chk("cmp", 32'h14, rd);
        pstrb <= 4'h0; apb(1'h1, 12'h00C, 8'h0); pstrb <= 4'hF;
        apb(1'h0, 12'h00C, 8'h0); chk("strb", 32'h14, rd);
        chk("flags", 32'h14, {24'h0, flg});
        apb(1'h0, 12'h010, 8'h0); chk("err", 32'h1, {31'h0, e});
        finish_test;
    end
endmodule : test_pif_flags
